// *** src/adc_serial_conv_interface.v ***
// serial conversion-control interface: conversion timing, config shift-in, result shift-out
`include "adc_conv_regs.vh"

module adc_serial_conv_interface (
   input  wire               mclk_i,
   input  wire               reset_i,
   // pins from the host
   input  wire               conversion_start_line_i,
   input  wire               sck_i,
   input  wire               din_i,
   // serial output pin as data and enable
   output wire               serial_result_out_o,
   output wire               serial_result_out_oe_o,
   // samples from the converter core
   input  wire [`RES_W-1:0]  sample_data_i,
   input  wire               sample_valid_i,
   output wire               sample_ready_o,
   // state shown to the rest of the chip
   output wire [`CFG_W-1:0]  config_o,
   output wire               config_update_o,
   output wire [`RES_W-1:0]  result_o,
   output wire               result_update_o,
   output wire               converting_o,
   output wire               power_down_o,
   output wire               busy_mode_o
);
   localparam integer           CONV_LAST_N = `CONV_CYCLES - 1;
   localparam [`CONV_CNT_W-1:0] CONV_LAST   = CONV_LAST_N[`CONV_CNT_W-1:0];

   // synchronised pins
   wire [2:0] pins_s;
   wire       start_s;
   wire       sck_s;
   wire       din_s;

   sync2 #(
      .W (3)
   ) u_pin_sync (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i ({conversion_start_line_i, sck_i, din_i}),
      .sync_o  (pins_s)
   );

   assign start_s = pins_s[2];
   assign sck_s   = pins_s[1];
   assign din_s   = pins_s[0];

   reg start_prev_q;
   reg sck_prev_q;

   wire start_rise = start_s & ~start_prev_q;
   wire start_fall = ~start_s & start_prev_q;
   wire sck_rise   = sck_s & ~sck_prev_q;
   wire sck_fall   = ~sck_s & sck_prev_q;

   // conversion state
   reg                   converting_q;
   reg [`CONV_CNT_W-1:0] conv_cnt_q;
   wire                  eoc = converting_q && (conv_cnt_q == CONV_LAST);

   // configuration path
   reg [`CFG_W-1:0] cfg_q;
   reg [`CFG_W-1:0] cfg_shift_q;
   reg [3:0]        cfg_cnt_q;
   reg              cfg_update_q;
   reg [`CFG_W-1:0] rb_cfg_q;

   // result path
   reg [`RES_W-1:0] result_q;
   reg              result_update_q;
   reg              data_avail_q;
   reg              busy_mode_q;
   reg              busy_pre_q;
   reg              oe_q;
   reg              out_bit_q;
   reg [`POS_W-1:0] pos_q;

   wire [`RES_W-1:0] fifo_data;
   wire              fifo_valid;

   // the source stalls on a full FIFO; at most one word is taken per end of conversion
   sample_fifo #(
      .W     (`RES_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .in_data_i   (sample_data_i),
      .in_valid_i  (sample_valid_i),
      .in_ready_o  (sample_ready_o),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (eoc)
   );

   // result followed by the configuration that went with it, MSB first
   wire [`WORD_W-1:0] out_word = {result_q, rb_cfg_q};

   wire [`POS_W-1:0] pos_last = (rb_cfg_q[`RB_BIT] == `RB_ON) ? `POS_LAST_RB : `POS_LAST_PLAIN;

   wire [`POS_W-1:0] pos_next = pos_q + 1'b1;

   function bit_at;
      input [`WORD_W-1:0] word;
      input [`POS_W-1:0]  pos;
      reg   [`POS_W-1:0]  idx;
      begin
         idx    = `POS_LAST_RB - pos;
         bit_at = word[idx];
      end
   endfunction

   // new result word for the cycle the result register is loaded; the old result when the FIFO is empty
   wire [`RES_W-1:0] new_result = fifo_valid ? fifo_data : result_q;

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         start_prev_q <= 1'b0;
         sck_prev_q   <= 1'b0;
      end else begin
         start_prev_q <= start_s;
         sck_prev_q   <= sck_s;
      end
   end

   // conversion timer
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         converting_q <= 1'b0;
         conv_cnt_q   <= {`CONV_CNT_W{1'b0}};
      end else if (converting_q) begin
         // start line edges are ignored until the timer expires
         if (eoc) begin
            converting_q <= 1'b0;
            conv_cnt_q   <= {`CONV_CNT_W{1'b0}};
         end else begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
         end
      end else if (start_rise) begin
         converting_q <= 1'b1;
         conv_cnt_q   <= {`CONV_CNT_W{1'b0}};
      end
   end

   // configuration shift-in on rising serial clock edges
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         cfg_q        <= `CFG_RESET;
         cfg_shift_q  <= {`CFG_W{1'b0}};
         cfg_cnt_q    <= 4'h0;
         cfg_update_q <= 1'b0;
         rb_cfg_q     <= `CFG_RESET;
      end else begin
         cfg_update_q <= 1'b0;
         if (eoc) begin
            // a partial word is dropped; the word in force goes with this result
            cfg_cnt_q <= 4'h0;
            rb_cfg_q  <= cfg_q;
         end else if (start_rise) begin
            // serial input is not sampled on a rising start edge
            cfg_cnt_q <= 4'h0;
         end else if (sck_rise && !start_s && cfg_cnt_q <= `CFG_LAST_BIT) begin
            cfg_shift_q <= {cfg_shift_q[`CFG_W-2:0], din_s};
            cfg_cnt_q   <= cfg_cnt_q + 1'b1;
            if (cfg_cnt_q == `CFG_LAST_BIT) begin
               cfg_q        <= {cfg_shift_q[`CFG_W-2:0], din_s};
               cfg_update_q <= 1'b1;
            end
         end
      end
   end

   // result shift-out on falling serial clock edges
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         result_q        <= {`RES_W{1'b0}};
         result_update_q <= 1'b0;
         data_avail_q    <= 1'b0;
         busy_mode_q     <= 1'b0;
         busy_pre_q      <= 1'b0;
         oe_q            <= 1'b0;
         out_bit_q       <= 1'b0;
         pos_q           <= {`POS_W{1'b0}};
      end else begin
         result_update_q <= 1'b0;
         if (eoc) begin
            // an unread old result is overwritten here
            result_q        <= new_result;
            result_update_q <= 1'b1;
            data_avail_q    <= 1'b1;
            pos_q           <= {`POS_W{1'b0}};
            busy_mode_q     <= ~start_s;
            if (!start_s) begin
               // last bit stood until now; pulling low marks the end of conversion
               busy_pre_q <= 1'b1;
               oe_q       <= 1'b1;
               out_bit_q  <= 1'b0;
            end else begin
               busy_pre_q <= 1'b0;
               oe_q       <= 1'b0;
               out_bit_q  <= new_result[`RES_W-1];
            end
         end else if (start_rise) begin
            oe_q       <= 1'b0;
            busy_pre_q <= 1'b0;
         end else if (start_fall) begin
            if (data_avail_q) begin
               oe_q      <= 1'b1;
               pos_q     <= {`POS_W{1'b0}};
               out_bit_q <= result_q[`RES_W-1];
            end
         end else if (sck_fall && !start_s && oe_q) begin
            // bits change only after a falling edge, so each spans a whole clock period
            if (busy_pre_q) begin
               busy_pre_q <= 1'b0;
               pos_q      <= {`POS_W{1'b0}};
               out_bit_q  <= result_q[`RES_W-1];
            end else if (pos_q == pos_last) begin
               oe_q         <= 1'b0;
               data_avail_q <= 1'b0;
            end else begin
               pos_q     <= pos_next;
               out_bit_q <= bit_at(out_word, pos_next);
            end
         end
      end
   end

   assign serial_result_out_o    = out_bit_q;
   assign serial_result_out_oe_o = oe_q;
   assign config_o               = cfg_q;
   assign config_update_o        = cfg_update_q;
   assign result_o               = result_q;
   assign result_update_o        = result_update_q;
   assign converting_o           = converting_q;
   assign power_down_o           = ~converting_q;
   assign busy_mode_o            = busy_mode_q;
endmodule

// *** src/adc_conv_regs.vh ***
// constants and timing counts for the serial conversion-control interface
`ifndef ADC_CONV_REGS_VH
`define ADC_CONV_REGS_VH

`define CLK_PERIOD_NS   10
`define CONV_TIME_NS    1600
`define CONV_CYCLES     ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W      8

`define RES_W           16
`define CFG_W           14
`define CFG_RESET       14'h3fff
`define CFG_LAST_BIT    4'hd
`define RB_BIT          0
`define RB_ON           1'b0

`define POS_W           5
`define POS_LAST_PLAIN  5'h0f
`define POS_LAST_RB     5'h1d
`define WORD_W          30

`define FIFO_DEPTH      16
`define FIFO_AW         4

`endif

// *** src/sync2.v ***
// two-flop synchroniser for levels arriving from outside the clock domain
module sync2 #(
   parameter W = 1
) (
   input  wire         mclk_i,
   input  wire         reset_i,
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

// *** src/sample_fifo.v ***
// flip-flop FIFO between the sample source and the conversion result register
module sample_fifo #(
   parameter W     = 16,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire         mclk_i,
   input  wire         reset_i,
   input  wire [W-1:0] in_data_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   output wire [W-1:0] out_data_o,
   output wire         out_valid_o,
   input  wire         out_ready_i
);
   reg  [AW-1:0] wr_ptr_q;
   reg  [AW-1:0] rd_ptr_q;
   reg  [AW:0]   count_q;
   wire          push;
   wire          pop;
   wire [W-1:0]  mem [0:DEPTH-1];

   // full count held at the pointer width plus one, so the compare needs no padding
   localparam [AW:0] FULL = DEPTH;

   assign in_ready_o  = (count_q != FULL);
   assign out_valid_o = (count_q != {(AW+1){1'b0}});
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign out_data_o  = mem[rd_ptr_q];

   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : entry
         localparam [AW-1:0] IDX = i;
         reg [W-1:0] data_q;
         always @(posedge mclk_i or posedge reset_i) begin
            if (reset_i) begin
               data_q <= {W{1'b0}};
            end else if (push && wr_ptr_q == IDX) begin
               data_q <= in_data_i;
            end
         end
         assign mem[i] = data_q;
      end
   endgenerate

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule

// *** tb/adc_serial_conv_interface_assertions.sv ***
// concurrent checks on the ports of the conversion-control interface
`include "adc_conv_regs.vh"
module adc_conv_chk (
   input wire logic              mclk_i,
   input wire logic              reset_i,
   input wire logic              conversion_start_line_i,
   input wire logic              sck_i,
   input wire logic              serial_result_out_o,
   input wire logic              serial_result_out_oe_o,
   input wire logic [`CFG_W-1:0] config_o,
   input wire logic              config_update_o,
   input wire logic              result_update_o,
   input wire logic              converting_o,
   input wire logic              power_down_o,
   input wire logic              busy_mode_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cnt_q;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // counts converting cycles so the length is checked without a long repetition
   always @(posedge mclk_i or posedge reset_i)
      if (reset_i)
         cnt_q <= 8'h00;
      else
         cnt_q <= converting_o ? cnt_q + 8'h01 : 8'h00;
   conv_len_a: assert property ($fell(converting_o) |-> cnt_q == `CONV_CYCLES)
      else $error("conversion length wrong");
   conv_max_a: assert property (converting_o |-> cnt_q < `CONV_CYCLES)
      else $error("conversion overran");
   power_down_a: assert property (power_down_o == !converting_o)
      else $error("power down not tied to idle");
   start_float_a: assert property ($rose(conversion_start_line_i) |-> ##[1:4] !serial_result_out_oe_o)
      else $error("output not floated on start");
   start_conv_a: assert property ($rose(conversion_start_line_i) && !converting_o |-> ##[2:5] converting_o)
      else $error("start not taken");
   cfg_commit_a: assert property ($changed(config_o) |-> config_update_o)
      else $error("config changed without commit");
   busy_low_a: assert property ($rose(serial_result_out_oe_o) && busy_mode_o |-> !serial_result_out_o)
      else $error("busy indication not low");
   out_hold_a: assert property ($changed(serial_result_out_o) |-> !$past(sck_i) && !$past(sck_i, 2))
      else $error("output moved while clock high");
   res_eoc_a: assert property (result_update_o |-> $past(converting_o) || $past(converting_o, 2))
      else $error("result update away from end of conversion");
   cover property ($fell(converting_o) && busy_mode_o);
   cover property (config_update_o);
   cover property ($fell(serial_result_out_oe_o));
endmodule
bind adc_serial_conv_interface adc_conv_chk i_adc_conv_chk (
   .mclk_i(mclk_i), .reset_i(reset_i), .conversion_start_line_i(conversion_start_line_i),
   .sck_i(sck_i), .serial_result_out_o(serial_result_out_o),
   .serial_result_out_oe_o(serial_result_out_oe_o), .config_o(config_o),
   .config_update_o(config_update_o), .result_update_o(result_update_o),
   .converting_o(converting_o), .power_down_o(power_down_o), .busy_mode_o(busy_mode_o)
);

// *** tb/host_spi_model.sv ***
// host model: drives start line, serial clock and config input, samples the output pin
module host_spi_model (
   input  wire logic res_out_i,
   input  wire logic res_oe_i,
   output logic      start_o,
   output logic      sck_o,
   output logic      din_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      start_o = 1'b0;
      sck_o = 1'b0;
      din_o = 1'b0;
   end
   // hold high keeps out of busy mode; otherwise drop well inside the conversion
   task automatic conv(input logic hold);
      start_o = 1'b0;
      #200;
      start_o = 1'b1;
      #300;
      start_o = hold;
      #1700;
   endtask
   // raise the start line and return while the conversion is still running
   task automatic kick;
      start_o = 1'b0;
      #200;
      start_o = 1'b1;
      #300;
   endtask
   // rx[0]/oer[0] before the first edge, rx[k]/oer[k] settled after falling edge k
   task automatic frame(input int n, input logic [13:0] cfg, output logic [31:0] rx, output logic [31:0] oer);
      rx = '0;
      oer = '0;
      din_o = cfg[13];
      start_o = 1'b0;
      #100;
      rx[0] = res_out_i;
      oer[0] = res_oe_i;
      for (int i = 1; i <= n; i++) begin
         sck_o = 1'b1;
         #62.5;
         sck_o = 1'b0;
         #50;
         rx[i] = res_out_i;
         oer[i] = res_oe_i;
         din_o = (i < 14) ? cfg[13-i] : 1'b0;
         #12.5;
      end
      din_o = ~din_o;
   endtask
endmodule

// *** tb/tb_adc_serial_conv_interface.sv ***
// self-checking bench for the serial conversion-control interface
`include "adc_conv_regs.vh"
module tb_adc_serial_conv_interface;
   timeunit 1ns;
   timeprecision 100ps;
   logic              mclk_i = 1'b0;
   logic              reset_i = 1'b1;
   logic [15:0]       sdata;
   logic              svalid;
   wire logic         start, sck, din, dout, doe, sready, cfg_upd, res_upd, conv, pd, busy;
   wire logic [13:0]  cfg;
   wire logic [15:0]  res;
   logic [31:0]       rx, oer;
   int                bad_count = 0;
   int                n_tests = 0;
   int                cyc = 0;
   int                n_cfg = 0;
   int                n_res = 0;
   // released output floats up to the pull-up level
   wire logic         pin = doe ? dout : 1'b1;
   adc_serial_conv_interface i_adc_serial_conv_interface (
      .mclk_i(mclk_i), .reset_i(reset_i), .conversion_start_line_i(start), .sck_i(sck), .din_i(din),
      .serial_result_out_o(dout), .serial_result_out_oe_o(doe), .sample_data_i(sdata),
      .sample_valid_i(svalid), .sample_ready_o(sready), .config_o(cfg), .config_update_o(cfg_upd),
      .result_o(res), .result_update_o(res_upd), .converting_o(conv), .power_down_o(pd),
      .busy_mode_o(busy));
   host_spi_model i_host_spi_model (.res_out_i(pin), .res_oe_i(doe), .start_o(start), .sck_o(sck), .din_o(din));
   always #5 mclk_i = ~mclk_i;
   // pulses are counted away from the launching edge so they are settled
   always @(negedge mclk_i) begin
      n_cfg += cfg_upd;
      n_res += res_upd;
   end
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         results;
      end
   end
   function automatic logic [15:0] w(input int i);
      return 16'h5a3c ^ (16'h1357 * 16'(i));
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %s: %h vs %h", $time, msg, seen, exp);
      end
   endtask
   task automatic chk_bits(input int first, input logic [15:0] v, input int n, input string msg);
      for (int j = 0; j < n; j++)
         chk(rx[first+j], v[n-1-j], msg);
   endtask
   task automatic results;
      if (bad_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_reset;
      chk(doe, 1'b0, "oe at reset");
      chk(cfg, 14'h3fff, "cfg at reset");
      chk(pd, 1'b1, "power down at reset");
   endtask
   task automatic t_fill;
      for (int i = 0; i < 17; i++) begin
         @(negedge mclk_i);
         sdata = w(i);
         svalid = 1'b1;
         #1 chk(sready, i < 16, "fifo ready");
      end
      @(negedge mclk_i);
      svalid = 1'b0;
   endtask
   task automatic t_plain;
      i_host_spi_model.conv(1'b1);
      chk(res, w(0), "result 0");
      chk(busy, 1'b0, "busy off");
      i_host_spi_model.frame(16, 14'h2a54, rx, oer);
      chk(oer[0], 1'b1, "oe on start fall");
      chk_bits(0, w(0), 16, "plain read");
      chk(oer[16:15], 2'b01, "oe after 16");
      chk(cfg, 14'h2a54, "cfg write");
   endtask
   task automatic t_rb;
      i_host_spi_model.conv(1'b1);
      i_host_spi_model.frame(30, 14'h3fff, rx, oer);
      chk_bits(0, w(1), 16, "rb result");
      chk_bits(16, 16'h2a54, 14, "rb config");
      chk(oer[30:29], 2'b01, "oe after 30");
   endtask
   task automatic t_busy;
      i_host_spi_model.conv(1'b0);
      chk(busy, 1'b1, "busy on");
      chk(res, w(2), "result 2");
      i_host_spi_model.frame(17, 14'h3fff, rx, oer);
      chk({oer[0], rx[0]}, 2'b10, "busy low");
      chk_bits(1, w(2), 16, "busy read");
      chk(oer[17:16], 2'b01, "oe after 17");
   endtask
   task automatic t_part;
      i_host_spi_model.conv(1'b1);
      i_host_spi_model.frame(5, 14'h0123, rx, oer);
      i_host_spi_model.conv(1'b1);
      chk(doe, 1'b0, "float while start high");
      chk(cfg, 14'h3fff, "partial cfg");
      i_host_spi_model.frame(16, 14'h1555, rx, oer);
      chk_bits(0, w(4), 16, "after lost read");
      chk(cfg, 14'h1555, "cfg after restart");
   endtask
   task automatic t_span;
      int c0;
      int r0;
      c0 = n_cfg;
      r0 = n_res;
      i_host_spi_model.kick;
      chk(conv, 1'b1, "converting after start");
      i_host_spi_model.frame(5, 14'h0123, rx, oer);
      chk(conv, 1'b1, "conversion runs on with start low");
      #1200;
      chk(n_res - r0, 1, "one result per conversion");
      chk(busy, 1'b1, "busy after low start");
      chk(cfg, 14'h1555, "partial cfg at eoc");
      i_host_spi_model.frame(17, 14'h2c4b, rx, oer);
      chk_bits(1, w(5), 16, "span read");
      chk(cfg, 14'h2c4b, "cfg after eoc restart");
      chk(n_cfg - c0, 1, "one commit per full word");
   endtask
   task automatic t_drain;
      for (int i = 6; i < 17; i++) begin
         i_host_spi_model.conv(1'b1);
         chk(res, w(i < 16 ? i : 15), "drain result");
      end
      chk(sready, 1'b1, "fifo empty ready");
      chk(conv, 1'b0, "idle after conversion");
   endtask
   initial begin
      sdata = 16'h0000;
      svalid = 1'b0;
      repeat (10) @(posedge mclk_i);
      @(negedge mclk_i);
      reset_i = 1'b0;
      t_reset;
      t_fill;
      t_plain;
      t_rb;
      t_busy;
      t_part;
      t_span;
      t_drain;
      results;
   end
endmodule
